// *** hdl/dsm_pkg.sv ***
// Functional notes
// RL1 - Enable set mixes selected carrier and keying; clear gives no modulated output.
// RL2 - Output status bit reads the present modulator output; writes ignored.
// RL3 - Readback is sampled on the register clock; fast carriers may misread.
// RL4 - Output invert select 1 inverts output, idles high; 0 idles low.
// RL5 - Software keying level 1 selects high carrier, 0 low carrier.
// RL6 - Software must pick the software level as keying source first.
// RL7 - High carrier invert 1 inverts the selected high carrier before mixing.
// RL8 - High sync set: leave high carrier only on its falling edge.
// RL9 - High sync clear: leave high carrier immediately on keying change.
// RL10 - Low carrier invert 1 inverts the selected low carrier before mixing.
// RL11 - Low sync set: leave low carrier only on its falling edge.
// RL12 - Low sync clear: leave low carrier immediately on keying change.
// RL13 - High selector codes map pin, clocks, capture, pwm, oscillator, logic cells.
// RL14 - Low selector uses the same codes; code 0 is its own pin.
// RL15 - Reserved low selector codes feed constant zero as carrier.
// RL16 - Unimplemented register bits read zero, writes to them ignored.
// RL17 - All implemented fields clear to zero on every reset.
// RL18 - Output is keying AND high carrier, or not keying AND low carrier.
// RL19 - Keying selector: code 1 software level, code 0 pin, unused zero.
// RL20 - Disabling keeps stored selections; they act again when re-enabled.
// RL21 - Reserved high selector codes feed constant zero as carrier.
// RL22 - Carrier inversion is applied before falling edge detection.
package dsm_pkg;
    localparam int         ADDR_W      = 3;
    localparam int         DATA_W      = 8;
    localparam int         SEL_W       = 5;
    localparam int         SRC_N       = 32;
    // Register offsets
    localparam logic [2:0] OFS_CON0    = 3'h0;
    localparam logic [2:0] OFS_CON1    = 3'h1;
    localparam logic [2:0] OFS_UPPER_CARRIER    = 3'h2;
    localparam logic [2:0] OFS_LOWER_CARRIER    = 3'h3;
    localparam logic [2:0] OFS_KSRC    = 3'h4;
    // Field positions
    localparam int         B_EN        = 7;
    localparam int         B_OUT       = 5;
    localparam int         B_OUTPUT_INVERT_SELECT      = 4;
    localparam int         B_BIT       = 0;
    localparam int         B_HIGH_CARRIER_INVERT     = 5;
    localparam int         B_HIGH_CARRIER_EDGE_SYNC    = 4;
    localparam int         B_LOW_CARRIER_INVERT     = 1;
    localparam int         B_LOW_CARRIER_EDGE_SYNC    = 0;
    // Writable masks and reset value
    localparam logic [7:0] CON0_WMASK  = 8'h91;
    localparam logic [7:0] CON1_WMASK  = 8'h33;
    localparam logic [7:0] SEL_WMASK   = 8'h1F;
    localparam logic [7:0] REG_RST     = 8'h00;
    // Carrier selector codes
    localparam logic [4:0] CAR_PIN     = 5'h00;
    localparam logic [4:0] CAR_NCO     = 5'h0E;
    localparam logic [4:0] CAR_RSV_A   = 5'h0C;
    localparam logic [4:0] CAR_RSV_B   = 5'h0D;
    localparam logic [4:0] CAR_LAST    = 5'h12;
    // Keying selector codes
    localparam logic [4:0] KEY_PIN     = 5'h00;
    localparam logic [4:0] KEY_BIT     = 5'h01;
    // Active carrier
    typedef enum logic {
        DSM_ACT_LOW  = 1'b0,
        DSM_ACT_HIGH = 1'b1
    } dsm_act_t;
endpackage : dsm_pkg

// *** hdl/dsm_top.sv ***
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module dsm_car_path (
    // Clock and control
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // Source selection
    input  wire logic [dsm_pkg::SRC_N-1:0]   src_vec,
    input  wire logic [dsm_pkg::SEL_W-1:0]   sel,
    input  wire logic                        invert,
    // Carrier out
    output logic                             car,
    output logic                             fall
);
    import dsm_pkg::*;

    logic prev_q;
    logic raw;

    assign raw  = src_vec[sel];                 // RL13 RL14
    assign car  = raw ^ invert;                 // RL7 RL10
    assign fall = prev_q & ~car;                // RL22

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= car;
        end
    end
endmodule : dsm_car_path

module dsm_top (
    // Clock, reset, enable
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // Register port
    input  wire logic [dsm_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [dsm_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [dsm_pkg::DATA_W-1:0]  reg_rdata,
    // Carrier sources
    input  wire logic                        high_carrier_pin_route,
    input  wire logic                        low_carrier_pin_route,
    input  wire logic                        system_clock_source,
    input  wire logic                        fast_internal_oscillator,
    input  wire logic                        reference_clock_output,
    input  wire logic [3:0]                  capture_out,
    input  wire logic [3:0]                  pwm_out,
    input  wire logic                        numeric_oscillator_output,
    input  wire logic [3:0]                  logic_cell_out,
    // Keying sources
    input  wire logic                        keying_pin,
    input  wire logic [1:0]                  comparator_out,
    input  wire logic [1:0]                  uart_tx,
    input  wire logic                        spi_data_out,
    input  wire logic                        can_tx,
    // Modulated output
    output logic                             mixed_output_pin
);
    import dsm_pkg::*;

    logic [7:0]       con0_q;
    logic [7:0]       con1_q;
    logic [7:0]       upper_carrier_q;
    logic [7:0]       lower_carrier_q;
    logic [7:0]       ksrc_q;
    logic [7:0]       rdata_q;
    logic             out_q;
    dsm_act_t         act_q;
    dsm_act_t         act_d;

    // Field decode
    wire              en      = con0_q[B_EN];
    wire              output_invert_select    = con0_q[B_OUTPUT_INVERT_SELECT];
    wire              sw_key  = con0_q[B_BIT];
    wire              high_carrier_invert   = con1_q[B_HIGH_CARRIER_INVERT];
    wire              high_carrier_edge_sync  = con1_q[B_HIGH_CARRIER_EDGE_SYNC];
    wire              low_carrier_invert   = con1_q[B_LOW_CARRIER_INVERT];
    wire              low_carrier_edge_sync  = con1_q[B_LOW_CARRIER_EDGE_SYNC];

    // Address decode
    wire              hit_con0 = (reg_addr == OFS_CON0);
    wire              hit_con1 = (reg_addr == OFS_CON1);
    wire              hit_upper_carrier = (reg_addr == OFS_UPPER_CARRIER);
    wire              hit_lower_carrier = (reg_addr == OFS_LOWER_CARRIER);
    wire              hit_ksrc = (reg_addr == OFS_KSRC);
    wire              wr_con0  = reg_wr & hit_con0;
    wire              wr_con1  = reg_wr & hit_con1;
    wire              wr_upper_carrier  = reg_wr & hit_upper_carrier;
    wire              wr_lower_carrier  = reg_wr & hit_lower_carrier;
    wire              wr_ksrc  = reg_wr & hit_ksrc;

    // Effective selections; disabled forces defaults, stored values kept
    wire [SEL_W-1:0]  hi_sel  = en ? upper_carrier_q[SEL_W-1:0] : CAR_PIN;   // RL20
    wire [SEL_W-1:0]  lo_sel  = en ? lower_carrier_q[SEL_W-1:0] : CAR_PIN;   // RL20
    wire [SEL_W-1:0]  key_sel = en ? ksrc_q[SEL_W-1:0] : KEY_BIT;   // RL20

    // Source vectors, reserved codes tied to zero
    wire [SRC_N-2:0]  car_com = {13'h0000, logic_cell_out, numeric_oscillator_output,
                                 2'h0, pwm_out, capture_out, reference_clock_output,
                                 fast_internal_oscillator, system_clock_source}; // RL15 RL21
    wire [SRC_N-1:0]  hi_vec  = {car_com, high_carrier_pin_route};   // RL13
    wire [SRC_N-1:0]  lo_vec  = {car_com, low_carrier_pin_route};    // RL14
    wire [SRC_N-1:0]  key_vec = {8'h00, can_tx, spi_data_out, 1'b0, uart_tx,
                                 logic_cell_out, comparator_out,
                                 numeric_oscillator_output, 2'h0, pwm_out,
                                 capture_out, sw_key, keying_pin};   // RL19
    wire              keying_input = key_vec[key_sel];               // RL5

    logic             upper_carrier;
    logic             lower_carrier;
    logic             hi_fall;
    logic             lo_fall;

    dsm_car_path u_hi (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .src_vec (hi_vec),
        .sel     (hi_sel),
        .invert  (high_carrier_invert),
        .car     (upper_carrier),
        .fall    (hi_fall)
    );

    dsm_car_path u_lo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .src_vec (lo_vec),
        .sel     (lo_sel),
        .invert  (low_carrier_invert),
        .car     (lower_carrier),
        .fall    (lo_fall)
    );

    // Active carrier selection with optional edge wait
    always_comb begin
        case (act_q)
            DSM_ACT_LOW: begin
                if (keying_input && (!low_carrier_edge_sync || lo_fall)) begin   // RL11 RL12
                    act_d = DSM_ACT_HIGH;
                end else begin
                    act_d = DSM_ACT_LOW;
                end
            end
            DSM_ACT_HIGH: begin
                if (!keying_input && (!high_carrier_edge_sync || hi_fall)) begin  // RL8 RL9
                    act_d = DSM_ACT_LOW;
                end else begin
                    act_d = DSM_ACT_HIGH;
                end
            end
            default: begin
                act_d = DSM_ACT_LOW;
            end
        endcase
    end

    // Mixing and output polarity
    wire              key_act    = (act_d == DSM_ACT_HIGH);
    wire              signal_mixer = (key_act & upper_carrier) |
                                     (~key_act & lower_carrier);   // RL18
    wire              out_d      = (en & signal_mixer) ^ output_invert_select;     // RL1 RL4

    // Read mux
    wire [7:0]        con0_rd = (con0_q & CON0_WMASK) |
                                ({7'h00, out_q} << B_OUT);         // RL2 RL3
    wire [7:0]        rd_mux  = hit_con0 ? con0_rd :
                                hit_con1 ? con1_q  :
                                hit_upper_carrier ? upper_carrier_q  :
                                hit_lower_carrier ? lower_carrier_q  :
                                hit_ksrc ? ksrc_q  : REG_RST;       // RL16

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            con0_q <= REG_RST;                                      // RL17
            con1_q <= REG_RST;
            upper_carrier_q <= REG_RST;
            lower_carrier_q <= REG_RST;
            ksrc_q <= REG_RST;
        end else if (ce) begin
            if (wr_con0) con0_q <= reg_wdata & CON0_WMASK;         // RL16
            if (wr_con1) con1_q <= reg_wdata & CON1_WMASK;
            if (wr_upper_carrier) upper_carrier_q <= reg_wdata & SEL_WMASK;
            if (wr_lower_carrier) lower_carrier_q <= reg_wdata & SEL_WMASK;
            if (wr_ksrc) ksrc_q <= reg_wdata & SEL_WMASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= REG_RST;
            out_q   <= 1'b0;
            act_q   <= DSM_ACT_LOW;
        end else if (ce) begin
            rdata_q <= reg_rd ? rd_mux : REG_RST;
            out_q   <= out_d;
            act_q   <= act_d;
        end
    end

    assign reg_rdata        = rdata_q;
    assign mixed_output_pin = out_q;

    // Checks
    wire lo_rsv = (lo_sel > CAR_LAST) || (lo_sel == CAR_RSV_A) || (lo_sel == CAR_RSV_B);
    wire hi_rsv = (hi_sel > CAR_LAST) || (hi_sel == CAR_RSV_A) || (hi_sel == CAR_RSV_B);

    property p_disabled_idle;
        @(posedge clk_sys) disable iff (rst)
        (ce && !en && !wr_con0) |=> (mixed_output_pin == $past(output_invert_select));
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)   // RL1
        else $error("disabled modulator drove a non-idle level");

    property p_readback;
        @(posedge clk_sys) disable iff (rst)
        (ce && reg_rd && hit_con0) |=> (reg_rdata[B_OUT] == $past(out_q));
    endproperty
    a_readback: assert property (p_readback)   // RL2
        else $error("output status readback mismatch");

    property p_out_read_only;
        @(posedge clk_sys) disable iff (rst)
        (ce && wr_con0) |=> (con0_q[B_OUT] == 1'b0);
    endproperty
    a_out_read_only: assert property (p_out_read_only)   // RL2
        else $error("write reached the output status bit");

    property p_polarity;
        @(posedge clk_sys) disable iff (rst)
        (ce && en && output_invert_select && !signal_mixer && !wr_con0) |=> mixed_output_pin;
    endproperty
    a_polarity: assert property (p_polarity)   // RL4
        else $error("inverted output failed to idle high");

    property p_soft_key;
        @(posedge clk_sys) disable iff (rst)
        (en && key_sel == KEY_BIT) |-> (keying_input == sw_key);
    endproperty
    a_soft_key: assert property (p_soft_key)   // RL5
        else $error("software level not used as keying input");

    property p_hi_inv;
        @(posedge clk_sys) disable iff (rst)
        (en && hi_sel == CAR_NCO) |-> (upper_carrier == (numeric_oscillator_output ^ high_carrier_invert));
    endproperty
    a_hi_inv: assert property (p_hi_inv)   // RL7
        else $error("high carrier inversion or selection wrong");

    property p_hi_wait;
        @(posedge clk_sys) disable iff (rst)
        (ce && act_q == DSM_ACT_HIGH && !keying_input && high_carrier_edge_sync && !hi_fall)
            |=> (act_q == DSM_ACT_HIGH);
    endproperty
    a_hi_wait: assert property (p_hi_wait)   // RL8
        else $error("left high carrier without its falling edge");

    property p_hi_now;
        @(posedge clk_sys) disable iff (rst)
        (ce && act_q == DSM_ACT_HIGH && !keying_input && !high_carrier_edge_sync)
            |=> (act_q == DSM_ACT_LOW);
    endproperty
    a_hi_now: assert property (p_hi_now)   // RL9
        else $error("unsynchronised switch off high carrier delayed");

    property p_lo_inv;
        @(posedge clk_sys) disable iff (rst)
        (en && lo_sel == CAR_NCO) |-> (lower_carrier == (numeric_oscillator_output ^ low_carrier_invert));
    endproperty
    a_lo_inv: assert property (p_lo_inv)   // RL10
        else $error("low carrier inversion or selection wrong");

    property p_lo_wait;
        @(posedge clk_sys) disable iff (rst)
        (ce && act_q == DSM_ACT_LOW && keying_input && low_carrier_edge_sync && !lo_fall)
            |=> (act_q == DSM_ACT_LOW);
    endproperty
    a_lo_wait: assert property (p_lo_wait)   // RL11
        else $error("left low carrier without its falling edge");

    property p_lo_now;
        @(posedge clk_sys) disable iff (rst)
        (ce && act_q == DSM_ACT_LOW && keying_input && !low_carrier_edge_sync)
            |=> (act_q == DSM_ACT_HIGH);
    endproperty
    a_lo_now: assert property (p_lo_now)   // RL12
        else $error("unsynchronised switch off low carrier delayed");

    property p_lo_rsv;
        @(posedge clk_sys) disable iff (rst)
        lo_rsv |-> (lower_carrier == low_carrier_invert);
    endproperty
    a_lo_rsv: assert property (p_lo_rsv)   // RL15
        else $error("reserved low code fed a live carrier");

    property p_hi_rsv;
        @(posedge clk_sys) disable iff (rst)
        hi_rsv |-> (upper_carrier == high_carrier_invert);
    endproperty
    a_hi_rsv: assert property (p_hi_rsv)   // RL21
        else $error("reserved high code fed a live carrier");

    property p_unimpl_zero;
        @(posedge clk_sys) disable iff (rst)
        (ce && reg_rd && hit_con1) |=> ((reg_rdata & ~CON1_WMASK) == REG_RST);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)   // RL16
        else $error("unimplemented bits read non-zero");

    property p_reset_clear;
        @(posedge clk_sys) disable iff (rst)
        $past(rst) |-> (con0_q == REG_RST && con1_q == REG_RST &&
                        upper_carrier_q == REG_RST && lower_carrier_q == REG_RST && ksrc_q == REG_RST);
    endproperty
    a_reset_clear: assert property (p_reset_clear)   // RL17
        else $error("register not cleared by reset");

    property p_mix_and;
        @(posedge clk_sys) disable iff (rst)
        (ce && en && !wr_con0 && key_act && !upper_carrier)
            |=> (mixed_output_pin == $past(output_invert_select));
    endproperty
    a_mix_and: assert property (p_mix_and)   // RL18
        else $error("output active while high carrier low");

    property p_disabled_key;
        @(posedge clk_sys) disable iff (rst)
        !en |-> (keying_input == sw_key && hi_sel == CAR_PIN && lo_sel == CAR_PIN);
    endproperty
    a_disabled_key: assert property (p_disabled_key)   // RL20
        else $error("disabled module kept non-default sources");

    property p_fall_inverted;
        @(posedge clk_sys) disable iff (rst)
        hi_fall |-> !upper_carrier;
    endproperty
    a_fall_inverted: assert property (p_fall_inverted)   // RL22
        else $error("edge detected on carrier before inversion");

    c_hi_sync_wait: cover property (@(posedge clk_sys) disable iff (rst)
        act_q == DSM_ACT_HIGH && !keying_input && high_carrier_edge_sync ##1 hi_fall);
    c_lo_switch: cover property (@(posedge clk_sys) disable iff (rst)
        en && act_q == DSM_ACT_LOW ##1 act_q == DSM_ACT_HIGH);
    c_inverted_out: cover property (@(posedge clk_sys) disable iff (rst)
        en && output_invert_select && mixed_output_pin);
endmodule : dsm_top

// *** testbench/dsm_src_model.sv ***
`timescale 1ns/1ps

module dsm_src_model (
    // Levels by index from the bench
    input  wire logic [26:0] lvl,
    // Carrier sources
    output logic             high_carrier_pin_route,
    output logic             low_carrier_pin_route,
    output logic             system_clock_source,
    output logic             fast_internal_oscillator,
    output logic             reference_clock_output,
    output logic [3:0]       capture_out,
    output logic [3:0]       pwm_out,
    output logic             numeric_oscillator_output,
    output logic [3:0]       logic_cell_out,
    // Keying-only sources
    output logic             keying_pin,
    output logic [1:0]       comparator_out,
    output logic [1:0]       uart_tx,
    output logic             spi_data_out,
    output logic             can_tx
);
    // Index is the carrier code; 19 low pin; 20 to 26 keying only
    assign high_carrier_pin_route    = lvl[0];
    assign system_clock_source       = lvl[1];
    assign fast_internal_oscillator  = lvl[2];
    assign reference_clock_output    = lvl[3];
    assign capture_out               = lvl[7:4];
    assign pwm_out                   = lvl[11:8];
    assign numeric_oscillator_output = lvl[14];
    assign logic_cell_out            = lvl[18:15];
    assign low_carrier_pin_route     = lvl[19];
    assign keying_pin                = lvl[20];
    assign comparator_out            = lvl[22:21];
    assign uart_tx                   = lvl[24:23];
    assign spi_data_out              = lvl[25];
    assign can_tx                    = lvl[26];
endmodule : dsm_src_model

// *** testbench/dsm_top_tb_top.sv ***
`timescale 1ns/1ps

module dsm_top_tb_top;
    import dsm_pkg::*;
    logic        clk_sys   = 1'b0;
    logic        rst       = 1'b1;
    logic        ce        = 1'b1;
    logic [2:0]  reg_addr  = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    logic [26:0] lvl       = 27'h0;
    logic        high_carrier_pin_route, low_carrier_pin_route;
    logic        system_clock_source, fast_internal_oscillator;
    logic        reference_clock_output, numeric_oscillator_output;
    logic [3:0]  capture_out, pwm_out, logic_cell_out;
    logic        keying_pin, spi_data_out, can_tx, mixed_output_pin;
    logic [1:0]  comparator_out, uart_tx;
    int unsigned mismatches = 0;
    int unsigned compares   = 0;
    int          i, k, s, n;

    always #2.5 clk_sys = ~clk_sys;

    dsm_src_model u_src (.lvl, .high_carrier_pin_route, .low_carrier_pin_route,
        .system_clock_source, .fast_internal_oscillator, .reference_clock_output,
        .capture_out, .pwm_out, .numeric_oscillator_output, .logic_cell_out,
        .keying_pin, .comparator_out, .uart_tx, .spi_data_out, .can_tx);

    dsm_top u_dut (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .high_carrier_pin_route, .low_carrier_pin_route,
        .system_clock_source, .fast_internal_oscillator, .reference_clock_output,
        .capture_out, .pwm_out, .numeric_oscillator_output, .logic_cell_out,
        .keying_pin, .comparator_out, .uart_tx, .spi_data_out, .can_tx,
        .mixed_output_pin);

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdc

    task automatic src(input logic [26:0] v);
        @(posedge clk_sys);
        lvl <= v;
    endtask : src

    task automatic outc(input logic e);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({7'h00, mixed_output_pin}, {7'h00, e});
    endtask : outc

    function automatic logic car_ok(input int c);
        return c <= 18 && c != 12 && c != 13;
    endfunction : car_ok

    function automatic int key_idx(input int c);
        if (c == 0) return 20;
        if (c >= 2 && c <= 9) return c + 2;
        if (c == 12) return 14;
        if (c == 13 || c == 14) return c + 8;
        if (c >= 15 && c <= 18) return c;
        if (c == 19 || c == 20) return c + 4;
        if (c == 22 || c == 23) return c + 3;
        return -1;
    endfunction : key_idx

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) rdc(i[2:0], 8'h00);
        outc(1'b0);
        // Writable bits, read-only status
        wr(OFS_CON0, 8'h6E);
        rdc(OFS_CON0, 8'h00);
        wr(OFS_CON0, 8'hFF);
        rdc(OFS_CON0, 8'hB1);
        wr(OFS_CON1, 8'hFF);
        rdc(OFS_CON1, 8'h33);
        @(posedge clk_sys);
        #1;
        chk(reg_rdata, 8'h00);
        for (i = 2; i < 5; i++) wr(i[2:0], 8'hFF);
        for (i = 2; i < 5; i++) rdc(i[2:0], 8'h1F);
        // Second reset in mid-run
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) rdc(i[2:0], 8'h00);
        // Clock enable low drops a write
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(OFS_UPPER_CARRIER, 8'h15);
        ce <= 1'b1;
        rdc(OFS_UPPER_CARRIER, 8'h00);
        wr(OFS_UPPER_CARRIER, 8'h15);
        rdc(OFS_UPPER_CARRIER, 8'h15);
        // Carrier selector scans
        wr(OFS_KSRC, {3'h0, KEY_BIT});
        for (k = 0; k < 2; k++) begin
            wr(OFS_CON0, k ? 8'h80 : 8'h81);
            for (i = 0; i < 32; i++) begin
                wr(k ? OFS_LOWER_CARRIER : OFS_UPPER_CARRIER, i[7:0]);
                n = (k && i == 0) ? 19 : i;
                src(27'h1 << n);
                outc(car_ok(i));
                src(~(27'h1 << n));
                outc(1'b0);
            end
        end
        // Keying selector scan
        wr(OFS_UPPER_CARRIER, 8'h01);
        wr(OFS_LOWER_CARRIER, {3'h0, CAR_RSV_A});
        wr(OFS_CON0, 8'h80);
        for (i = 0; i < 32; i++) begin
            wr(OFS_KSRC, i[7:0]);
            n = key_idx(i);
            src(n < 0 ? 27'h2 : 27'h2 | (27'h1 << n));
            outc(n >= 0);
            src(n < 0 ? 27'h7FFFFFF : ~(27'h1 << n));
            outc(1'b0);
        end
        // Carrier and output polarity, enable
        wr(OFS_KSRC, 8'h01);
        src(27'h0);
        wr(OFS_CON1, 8'h02);
        outc(1'b1);
        wr(OFS_CON1, 8'h20);
        wr(OFS_CON0, 8'h81);
        outc(1'b1);
        wr(OFS_UPPER_CARRIER, 8'h1F);
        outc(1'b1);
        wr(OFS_CON1, 8'h00);
        wr(OFS_LOWER_CARRIER, 8'h01);
        src(27'h2);
        wr(OFS_CON0, 8'h80);
        outc(1'b1);
        wr(OFS_CON0, 8'h00);
        outc(1'b0);
        wr(OFS_CON0, 8'h10);
        outc(1'b1);
        rdc(OFS_LOWER_CARRIER, 8'h01);
        wr(OFS_CON0, 8'h90);
        outc(1'b0);
        // Carrier switch with and without edge sync
        wr(OFS_UPPER_CARRIER, 8'h01);
        wr(OFS_LOWER_CARRIER, 8'h02);
        for (k = 0; k < 2; k++) begin
            for (s = 0; s < 2; s++) begin
                wr(OFS_CON1, s ? (k ? 8'h01 : 8'h10) : 8'h00);
                wr(OFS_CON0, k ? 8'h80 : 8'h81);
                src(k ? 27'h4 : 27'h2);
                outc(1'b1);
                wr(OFS_CON0, k ? 8'h81 : 8'h80);
                outc(s[0]);
                if (s) begin
                    src(27'h0);
                    outc(1'b0);
                    src(k ? 27'h4 : 27'h2);
                    outc(1'b0);
                end
            end
        end
        test_done();
    end
endmodule : dsm_top_tb_top
